/* verilog/nvac_pkg.sv */
// Shared constants for the nonvolatile memory access controller
package nvac_pkg;
    // APB address width and register byte offsets
    localparam int          APB_AW          = 12;
    localparam logic [11:0] OFS_ADDR_LOW    = 12'h100;
    localparam logic [11:0] OFS_ADDR_HIGH   = 12'h104;
    localparam logic [11:0] OFS_DATA_LOW    = 12'h108;
    localparam logic [11:0] OFS_DATA_HIGH   = 12'h10C;
    localparam logic [11:0] OFS_UNLOCK      = 12'h110;
    localparam logic [11:0] OFS_STATUS      = 12'h114;
    localparam logic [11:0] OFS_CONTROL     = 12'h18C;

    // Control register field positions
    localparam int BIT_READ   = 0;
    localparam int BIT_WRITE  = 1;
    localparam int BIT_ARM    = 2;
    localparam int BIT_ABORT  = 3;
    localparam int BIT_SELECT = 7;
    // Status register field position
    localparam int BIT_DONE   = 0;

    // Unlock key bytes
    localparam logic [7:0] KEY_FIRST  = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;

    // Reset values
    localparam logic [7:0] RST_BYTE   = 8'h00;
    localparam logic [7:0] ERASED     = 8'hFF;

    // Read latencies in instruction cycles
    localparam logic [1:0] EE_READ_CYCLES    = 2'h1;
    localparam logic [1:0] FLASH_READ_CYCLES = 2'h2;

    // Write timing: erase then program phase
    localparam int CLK_MHZ        = 40;
    localparam int ERASE_TIME_NS  = 2000;
    localparam int PROG_TIME_NS   = 2000;
    localparam int ERASE_CYCLES   = (ERASE_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int PROG_CYCLES    = (PROG_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int TIMER_W        = 12;

    // Unlock key tracker states
    typedef enum logic [1:0] {
        KEY_IDLE = 2'b00,
        KEY_HALF = 2'b01,
        KEY_FULL = 2'b10
    } nvac_key_t;

    // Write engine states
    typedef enum logic [1:0] {
        ENG_IDLE  = 2'b00,
        ENG_ERASE = 2'b01,
        ENG_PROG  = 2'b10
    } nvac_eng_t;
endpackage

/* verilog/nvac_eeprom.sv */
// Data EEPROM array with erase-then-program write engine
module nvac_eeprom #(
    parameter int EE_AW = 8
) (
    // Clock and reset
    input  wire logic             i_clock,
    input  wire logic             i_resetn,
    input  wire logic             i_abort,
    // Write request
    input  wire logic             i_start,
    input  wire logic [EE_AW-1:0] i_waddr,
    input  wire logic [7:0]       i_wdata,
    // Read port
    input  wire logic [EE_AW-1:0] i_raddr,
    output logic      [7:0]       o_rdata,
    // Engine status
    output logic                  o_busy,
    output logic                  o_done
);
    import nvac_pkg::*;

    localparam logic [TIMER_W-1:0] ERASE_LAST = TIMER_W'(ERASE_CYCLES - 1);
    localparam logic [TIMER_W-1:0] PROG_LAST  = TIMER_W'(PROG_CYCLES - 1);

    // Elaboration checks on address width and timer range
    if (EE_AW < 1 || EE_AW > 12) begin : g_bad_aw
        $error("EE_AW out of range");
    end
    if (ERASE_CYCLES >= (1 << TIMER_W) ||
        PROG_CYCLES >= (1 << TIMER_W)) begin : g_bad_timer
        $error("Write timer too narrow");
    end

    // Cell storage, not reset: contents survive like real cells
    logic [7:0]       mem [0:(1<<EE_AW)-1];
    nvac_eng_t        state_ff;
    logic [TIMER_W-1:0] timer_ff;
    logic [EE_AW-1:0] addr_ff;
    logic [7:0]       data_ff;
    logic             done_ff;

    // Timer expiry
    wire phase_end = (state_ff == ENG_ERASE && timer_ff == ERASE_LAST) ||
                     (state_ff == ENG_PROG  && timer_ff == PROG_LAST);

    assign o_rdata = mem[i_raddr];
    assign o_busy  = (state_ff != ENG_IDLE);
    assign o_done  = done_ff;

    // Sequencer: erase phase first, then program phase
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            state_ff <= ENG_IDLE;
            timer_ff <= '0;
            addr_ff  <= '0;
            data_ff  <= RST_BYTE;
            done_ff  <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            timer_ff <= phase_end ? '0 : timer_ff + 1'b1;
            if (i_abort) begin
                state_ff <= ENG_IDLE; // Warm reset kills the cycle
            end else begin
                unique case (state_ff)
                    ENG_IDLE: begin
                        timer_ff <= '0;
                        if (i_start) begin
                            state_ff <= ENG_ERASE;
                            addr_ff  <= i_waddr;
                            data_ff  <= i_wdata;
                        end
                    end
                    ENG_ERASE: if (phase_end) state_ff <= ENG_PROG;
                    ENG_PROG: begin
                        if (phase_end) begin
                            state_ff <= ENG_IDLE;
                            done_ff  <= 1'b1;
                        end
                    end
                    default: state_ff <= ENG_IDLE;
                endcase
            end
        end
    end

    // Cell updates: erase sets all ones, program stores the byte
    always_ff @(posedge i_clock) begin
        if (!i_abort && phase_end && state_ff == ENG_ERASE)
            mem[addr_ff] <= ERASED;
        if (!i_abort && phase_end && state_ff == ENG_PROG)
            mem[addr_ff] <= data_ff;
    end
endmodule

/* verilog/nvac_ctrl.sv */
// APB register front end of the nonvolatile memory access controller
// Behaviour
// - EEPROM read lands in data low next cycle
// - Data low holds byte until read/write
// - Write start needs arm set earlier
// - Clearing arm never aborts running write
// - Write end clears start, sets done flag
// - Flash read takes two cycles
// - Flash word held in data pair
// - Read start clears itself, not by firmware
// - Erase then program, core keeps running
// - Warm reset during write sets abort flag
//
// Chosen here: register access over APB.
module nvac_ctrl #(
    parameter int EE_AW  = 8,
    parameter int PROG_W = 14,
    parameter int PA_W   = 13
) (
    // Clock and resets
    input  wire logic                       I_CLOCK,
    input  wire logic                       I_RESETN,
    input  wire logic                       I_WARM_RESET,
    // APB slave
    input  wire logic                       I_PSEL,
    input  wire logic                       I_PENABLE,
    input  wire logic                       I_PWRITE,
    input  wire logic [nvac_pkg::APB_AW-1:0] I_PADDR,
    input  wire logic [31:0]                I_PWDATA,
    output logic      [31:0]                O_PRDATA,
    output logic                            O_PREADY,
    output logic                            O_PSLVERR,
    // Program memory read port
    output logic      [PA_W-1:0]            O_PROG_ADDR,
    input  wire logic [PROG_W-1:0]          I_PROG_RDATA
);
    import nvac_pkg::*;

    localparam int DH_W = PROG_W - 8;
    localparam int AH_W = PA_W - 8;

    // Elaboration checks: high parts and the EEPROM address must fit one byte register
    if (PROG_W < 9 || PROG_W > 16) begin : g_bad_prog_w
        $error("PROG_W out of range");
    end
    if (PA_W < 9 || PA_W > 16) begin : g_bad_pa_w
        $error("PA_W out of range");
    end
    if (EE_AW < 1 || EE_AW > 8) begin : g_bad_ee_aw
        $error("EE_AW out of range");
    end

    // Registers
    logic [7:0]      addr_low_ff;
    logic [AH_W-1:0] addr_high_ff;
    logic [7:0]      data_low_ff;
    logic [DH_W-1:0] data_high_ff;
    logic            select_ff;
    logic            abort_ff;
    logic            arm_ff;
    logic            write_ff;
    logic            read_ff;
    logic [1:0]      read_cnt_ff;
    logic            done_ff;
    nvac_key_t       key_ff;
    nvac_key_t       nxt_key;
    logic [31:0]     prdata_ff;

    // Engine wires
    logic [7:0]      ee_rdata;
    logic            eng_busy;
    logic            eng_done;

    // APB decode
    wire acc        = I_PSEL & I_PENABLE;
    wire setup      = I_PSEL & ~I_PENABLE;
    wire wr_acc     = acc & I_PWRITE;
    wire [7:0] wb   = I_PWDATA[7:0];
    wire hit_al     = (I_PADDR == OFS_ADDR_LOW);
    wire hit_ah     = (I_PADDR == OFS_ADDR_HIGH);
    wire hit_dl     = (I_PADDR == OFS_DATA_LOW);
    wire hit_dh     = (I_PADDR == OFS_DATA_HIGH);
    wire hit_un     = (I_PADDR == OFS_UNLOCK);
    wire hit_st     = (I_PADDR == OFS_STATUS);
    wire hit_ct     = (I_PADDR == OFS_CONTROL);
    wire mapped     = hit_al | hit_ah | hit_dl | hit_dh | hit_un |
                      hit_st | hit_ct;
    wire wr_ct      = wr_acc & hit_ct;

    // Start requests
    wire rd_req     = wr_ct & wb[BIT_READ] & ~read_ff;
    // Arm must already be set; key must be complete right before
    wire wr_req     = wr_ct & wb[BIT_WRITE] & arm_ff & ~write_ff &
                      (key_ff == KEY_FULL) & ~wb[BIT_SELECT];
    wire read_last  = read_ff & (read_cnt_ff == 2'h1);
    wire ee_load    = read_last & ~select_ff;
    wire pm_load    = read_last & select_ff;
    wire running    = write_ff | eng_busy;

    // Key tracker: any other write breaks the sequence
    always_comb begin
        nxt_key = key_ff;
        if (wr_acc) begin
            if (hit_un && wb == KEY_FIRST)
                nxt_key = KEY_HALF;
            else if (hit_un && wb == KEY_SECOND && key_ff == KEY_HALF)
                nxt_key = KEY_FULL;
            else
                nxt_key = KEY_IDLE;
        end
    end

    // Read mux, byte registers sit in low bits
    wire [31:0] rd_mux =
        hit_al ? {24'h000000, addr_low_ff} :
        hit_ah ? {{(32-AH_W){1'b0}}, addr_high_ff} :
        hit_dl ? {24'h000000, data_low_ff} :
        hit_dh ? {{(32-DH_W){1'b0}}, data_high_ff} :
        hit_st ? {31'h00000000, done_ff} :
        hit_ct ? {24'h000000, select_ff, 3'h0, abort_ff, arm_ff,
                  write_ff, read_ff} :
        32'h00000000;

    // Zero wait state slave; data snapped in the setup cycle
    assign O_PREADY    = 1'b1;
    assign O_PSLVERR   = acc & ~mapped;
    assign O_PRDATA    = prdata_ff;
    assign O_PROG_ADDR = {addr_high_ff, addr_low_ff};

    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) prdata_ff <= 32'h00000000;
        else if (setup) prdata_ff <= rd_mux;
    end

    // Address, select and data survive warm reset
    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            addr_low_ff  <= RST_BYTE;
            addr_high_ff <= '0;
            select_ff    <= 1'b0;
        end else if (!I_WARM_RESET) begin
            if (wr_acc && hit_al) addr_low_ff <= wb;
            if (wr_acc && hit_ah) addr_high_ff <= wb[AH_W-1:0];
            if (wr_ct) select_ff <= wb[BIT_SELECT];
        end
    end

    // Data pair: hardware load wins over a firmware write
    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            data_low_ff  <= RST_BYTE;
            data_high_ff <= '0;
        end else if (ee_load) begin
            data_low_ff  <= ee_rdata;
        end else if (pm_load) begin
            data_low_ff  <= I_PROG_RDATA[7:0];
            data_high_ff <= I_PROG_RDATA[PROG_W-1:8];
        end else if (!I_WARM_RESET) begin
            // Otherwise held until firmware writes
            if (wr_acc && hit_dl) data_low_ff <= wb;
            if (wr_acc && hit_dh) data_high_ff <= wb[DH_W-1:0];
        end
    end

    // Read start: set by firmware only, cleared at end
    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            read_ff     <= 1'b0;
            read_cnt_ff <= 2'h0;
        end else if (I_WARM_RESET) begin
            read_ff     <= 1'b0;
            read_cnt_ff <= 2'h0;
        end else if (rd_req) begin
            read_ff     <= 1'b1;
            // One cycle for EEPROM, two for flash
            read_cnt_ff <= wb[BIT_SELECT] ? FLASH_READ_CYCLES
                                          : EE_READ_CYCLES;
        end else if (read_ff) begin
            read_cnt_ff <= read_cnt_ff - 2'h1;
            if (read_last) read_ff <= 1'b0;
        end
    end

    // Arm bit is plain R/W and does not touch the engine
    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) arm_ff <= 1'b0;
        else if (I_WARM_RESET) arm_ff <= 1'b0;
        else if (wr_ct) arm_ff <= wb[BIT_ARM];
    end

    // Write start: set only via unlock path, cleared on finish
    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) write_ff <= 1'b0;
        else if (I_WARM_RESET) write_ff <= 1'b0;
        else if (wr_req) write_ff <= 1'b1;
        else if (eng_done) write_ff <= 1'b0;
    end

    // Abort flag: warm reset mid-write sets it, firmware may rewrite
    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) abort_ff <= 1'b0;
        else if (I_WARM_RESET && running) abort_ff <= 1'b1;
        else if (!I_WARM_RESET && wr_ct) abort_ff <= wb[BIT_ABORT];
    end

    // Done flag: sticky, set beats a same-cycle clear
    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) done_ff <= 1'b0;
        else if (eng_done) done_ff <= 1'b1;
        else if (wr_acc && hit_st) done_ff <= wb[BIT_DONE];
    end

    // Key tracker state; warm reset drops a half-entered key
    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) key_ff <= KEY_IDLE;
        else if (I_WARM_RESET) key_ff <= KEY_IDLE;
        else key_ff <= nxt_key;
    end

    // Write engine runs beside the core
    nvac_eeprom #(
        .EE_AW (EE_AW)
    ) u_eeprom (
        .i_clock  (I_CLOCK),
        .i_resetn (I_RESETN),
        .i_abort  (I_WARM_RESET),
        .i_start  (wr_req),
        .i_waddr  (addr_low_ff[EE_AW-1:0]),
        .i_wdata  (data_low_ff),
        .i_raddr  (addr_low_ff[EE_AW-1:0]),
        .o_rdata  (ee_rdata),
        .o_busy   (eng_busy),
        .o_done   (eng_done)
    );
endmodule

/* tb/nvac_ctrl_checker.sv */
// Port-level assertions for the nonvolatile memory access controller
module nvac_ctrl_checker
    import nvac_pkg::*;
#(
    parameter int EE_AW  = 8,
    parameter int PROG_W = 14,
    parameter int PA_W   = 13
) (
    // Clock and resets
    input wire logic                        I_CLOCK,
    input wire logic                        I_RESETN,
    input wire logic                        I_WARM_RESET,
    // APB
    input wire logic                        I_PSEL,
    input wire logic                        I_PENABLE,
    input wire logic                        I_PWRITE,
    input wire logic [nvac_pkg::APB_AW-1:0] I_PADDR,
    input wire logic [31:0]                 I_PWDATA,
    input wire logic [31:0]                 O_PRDATA,
    input wire logic                        O_PREADY,
    input wire logic                        O_PSLVERR,
    // Program memory port
    input wire logic [PA_W-1:0]             O_PROG_ADDR,
    input wire logic [PROG_W-1:0]           I_PROG_RDATA
);
    logic [7:0] age_ff;
    logic       k1_ff;
    logic       k2_ff;
    // Transfer decode
    wire wr     = I_PSEL && I_PENABLE && I_PWRITE;
    wire ctl_wr = wr && (I_PADDR == OFS_CONTROL);
    wire ctl_rd = I_PSEL && !I_PENABLE && !I_PWRITE && I_PADDR == OFS_CONTROL;
    wire adr_wr = wr && (I_PADDR == OFS_ADDR_LOW || I_PADDR == OFS_ADDR_HIGH);
    wire mapped = I_PADDR inside {OFS_ADDR_LOW, OFS_ADDR_HIGH, OFS_DATA_LOW,
        OFS_DATA_HIGH, OFS_UNLOCK, OFS_STATUS, OFS_CONTROL};
    // Age since last start attempt; saturates so long idle stays known
    wire       start_try = ctl_wr && (I_PWDATA[0] || I_PWDATA[1]);
    wire [7:0] nxt_age   = start_try ? 8'h00 :
                           (age_ff == 8'hFF) ? age_ff : age_ff + 8'h01;
    wire nxt_k1 = wr ? (I_PADDR == OFS_UNLOCK && I_PWDATA[7:0] == KEY_FIRST)
                     : k1_ff;
    wire nxt_k2 = wr ? (I_PADDR == OFS_UNLOCK && I_PWDATA[7:0] == KEY_SECOND
                        && k1_ff) : k2_ff;
    // Helper state
    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            age_ff <= 8'h00;
            k1_ff  <= 1'b0;
            k2_ff  <= 1'b0;
        end else begin
            age_ff <= nxt_age;
            k1_ff  <= nxt_k1;
            k2_ff  <= nxt_k2;
        end
    end

    default clocking @(posedge I_CLOCK); endclocking
    default disable iff (!I_RESETN);

    a_ready_no_wait: assert property (I_PSEL && I_PENABLE |-> O_PREADY)
        else $error("pready low in access phase");
    a_slverr_map: assert property (
        I_PSEL && I_PENABLE |-> O_PSLVERR == !mapped)
        else $error("pslverr does not match address map");
    a_addr_low_load: assert property (
        wr && I_PADDR == OFS_ADDR_LOW && !I_WARM_RESET
        |=> O_PROG_ADDR[7:0] == $past(I_PWDATA[7:0]))
        else $error("address low not loaded");
    a_addr_high_load: assert property (
        wr && I_PADDR == OFS_ADDR_HIGH && !I_WARM_RESET
        |=> O_PROG_ADDR[PA_W-1:8] == $past(I_PWDATA[PA_W-9:0]))
        else $error("address high not loaded");
    a_addr_kept: assert property (
        !$past(adr_wr) |-> $stable(O_PROG_ADDR))
        else $error("address changed without a write");
    a_read_self_clear: assert property (
        ctl_rd && age_ff >= 3 |=> !O_PRDATA[0])
        else $error("read start bit stuck");
    a_write_ends: assert property (
        ctl_rd && age_ff >= 200 |=> !O_PRDATA[1])
        else $error("write start bit not cleared");
    a_keyless_start: assert property (
        ctl_wr && I_PWDATA[1] && !k2_ff && age_ff >= 200 ##[1:3] ctl_rd
        |=> !O_PRDATA[1])
        else $error("write started without unlock key");
endmodule

bind nvac_ctrl nvac_ctrl_checker #(.EE_AW(EE_AW), .PROG_W(PROG_W),
    .PA_W(PA_W)) u_chk (.I_CLOCK(I_CLOCK), .I_RESETN(I_RESETN),
    .I_WARM_RESET(I_WARM_RESET), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
    .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
    .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
    .O_PROG_ADDR(O_PROG_ADDR), .I_PROG_RDATA(I_PROG_RDATA));

/* tb/nv_memory_access_ctrl_tb_top.sv */
// Self-checking bench for the nonvolatile memory access controller
module nv_memory_access_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import nvac_pkg::*;
    logic        clock      = 1'b0;
    logic        resetn     = 1'b0;
    logic        warm       = 1'b0;
    logic        psel       = 1'b0;
    logic        penable    = 1'b0;
    logic        pwrite     = 1'b0;
    logic [11:0] paddr      = 12'h000;
    logic [31:0] pwdata     = 32'h0;
    logic [13:0] prog_rdata = 14'h0000;
    wire  [31:0] prdata;
    wire         pready;
    wire         pslverr;
    wire  [12:0] prog_addr;
    int          errors     = 0;
    int          n_tests    = 0;
    int          cyc        = 0;

    nvac_ctrl #(.EE_AW(8), .PROG_W(14), .PA_W(13)) dut (
        .I_CLOCK(clock), .I_RESETN(resetn), .I_WARM_RESET(warm),
        .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
        .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
        .O_PREADY(pready), .O_PSLVERR(pslverr),
        .O_PROG_ADDR(prog_addr), .I_PROG_RDATA(prog_rdata));

    // 40 MHz clock
    always #12.5 clock = ~clock;

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Hang guard, well above the several hundred cycles the run needs
    always @(posedge clock) begin
        cyc++;
        if (cyc == 6000) begin
            errors++;
            wrap_up();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; request held until pready seen at an edge
    task automatic apb(input logic [11:0] a, input logic w,
                       input logic [7:0] d, output logic [31:0] r,
                       output logic e);
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h0, d};
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        apb(a, 1'b1, d, r, e);
    endtask

    // Masked read; bits above the byte must read zero as well
    task automatic rdc(input logic [11:0] a, input logic [7:0] m,
                       input logic [7:0] x);
        logic [31:0] r;
        logic        e;
        apb(a, 1'b0, 8'h00, r, e);
        check(r & {24'hFFFFFF, m}, {24'h0, x});
    endtask

    // Key bytes go back to back, nothing may slip between
    task automatic key(input logic [7:0] d1, input logic [7:0] d2);
        wr(OFS_UNLOCK, d1);
        wr(OFS_UNLOCK, d2);
    endtask

    task automatic t_regs;
        logic [31:0] r;
        logic        e;
        rdc(OFS_CONTROL, 8'hFF, 8'h00);
        rdc(OFS_STATUS, 8'hFF, 8'h00);
        wr(OFS_ADDR_HIGH, 8'hFF);
        rdc(OFS_ADDR_HIGH, 8'hFF, 8'h1F);
        wr(OFS_CONTROL, 8'h70);
        rdc(OFS_CONTROL, 8'hFF, 8'h00);
        rdc(OFS_UNLOCK, 8'hFF, 8'h00);
        apb(12'h200, 1'b0, 8'h00, r, e);
        check({31'h0, e}, 32'h1);
    endtask

    task automatic t_eewrite;
        logic [31:0] r;
        logic        e;
        int          i;
        wr(OFS_ADDR_LOW, 8'h12);
        wr(OFS_DATA_LOW, 8'h3C);
        wr(OFS_CONTROL, 8'h04);
        // Long idle so the checker knows the write bit is clear
        repeat (200) @(posedge clock);
        wr(OFS_UNLOCK, KEY_FIRST);
        wr(OFS_ADDR_LOW, 8'h12);
        wr(OFS_UNLOCK, KEY_SECOND);
        wr(OFS_CONTROL, 8'h06);
        rdc(OFS_CONTROL, 8'h02, 8'h00);
        wr(OFS_CONTROL, 8'h00);
        key(KEY_FIRST, KEY_SECOND);
        wr(OFS_CONTROL, 8'h06);
        rdc(OFS_CONTROL, 8'h02, 8'h00);
        key(KEY_FIRST, KEY_SECOND);
        wr(OFS_CONTROL, 8'h06);
        rdc(OFS_CONTROL, 8'h02, 8'h02);
        wr(OFS_CONTROL, 8'h00);
        repeat (90) @(posedge clock);
        wr(OFS_CONTROL, 8'h01);
        rdc(OFS_DATA_LOW, 8'hFF, ERASED);
        r = 32'h2;
        // Poll the write bit until the cycle ends
        for (i = 0; i < 100 && r[1] !== 1'b0; i++) begin
            apb(OFS_CONTROL, 1'b0, 8'h00, r, e);
        end
        check({31'h0, r[1]}, 32'h0);
        rdc(OFS_STATUS, 8'hFF, 8'h01);
        // Quiet spell so the checker sees the write bit stay clear
        repeat (170) @(posedge clock);
        rdc(OFS_CONTROL, 8'h02, 8'h00);
        wr(OFS_CONTROL, 8'h01);
        rdc(OFS_DATA_LOW, 8'hFF, 8'h3C);
        rdc(OFS_CONTROL, 8'h01, 8'h00);
        wr(OFS_ADDR_LOW, 8'h40);
        rdc(OFS_DATA_LOW, 8'hFF, 8'h3C);
        wr(OFS_STATUS, 8'h00);
        rdc(OFS_STATUS, 8'hFF, 8'h00);
        wr(OFS_ADDR_LOW, 8'h12);
    endtask

    task automatic t_flash;
        prog_rdata <= 14'h2ABC;
        wr(OFS_ADDR_LOW, 8'h34);
        wr(OFS_ADDR_HIGH, 8'h12);
        // Address register settles after the write edge
        @(negedge clock);
        check({19'h0, prog_addr}, 32'h1234);
        wr(OFS_CONTROL, 8'h81);
        // Two idle cycles while the word is fetched
        repeat (2) @(posedge clock);
        rdc(OFS_DATA_LOW, 8'hFF, 8'hBC);
        rdc(OFS_DATA_HIGH, 8'hFF, 8'h2A);
        prog_rdata <= 14'h1555;
        rdc(OFS_DATA_LOW, 8'hFF, 8'hBC);
        rdc(OFS_CONTROL, 8'hFF, 8'h80);
        wr(OFS_ADDR_LOW, 8'h12);
    endtask

    task automatic t_warm;
        wr(OFS_CONTROL, 8'h04);
        wr(OFS_DATA_LOW, 8'h5A);
        key(KEY_FIRST, KEY_SECOND);
        wr(OFS_CONTROL, 8'h06);
        repeat (20) @(posedge clock);
        warm <= 1'b1;
        repeat (2) @(posedge clock);
        warm <= 1'b0;
        rdc(OFS_CONTROL, 8'hFF, 8'h08);
        rdc(OFS_ADDR_LOW, 8'hFF, 8'h12);
        rdc(OFS_DATA_LOW, 8'hFF, 8'h5A);
        rdc(OFS_STATUS, 8'hFF, 8'h00);
    endtask

    initial begin
        repeat (8) @(posedge clock);
        resetn <= 1'b1;
        t_regs();
        t_eewrite();
        t_flash();
        t_warm();
        wrap_up();
    end
endmodule
